// *** src/cig_logic.sv ***
// cig_logic: codec interrupt combiner, pin input conditioning, pin output routing.
// assumes AXI4-Lite master on clk_i, all pins synchronous to clk_i,
// slow timeout clock given as a level sampled on clk_i.
// Operation
// - selector 0010/0011 drives constant low/high
// - flag is OR of enabled status bits
// - invert bit makes pin flag active low
// - sources: buttons, jacks, bias, lock, temperature
// - status latches; write one clears it
// - per-source enable gates flag contribution
// - status latches regardless of enable
// - flag readback read-only, follows enabled status
// - level-sensitive: active source sets again
// - selector 0111 drives flag onto pin
// - output pins block their own input
// - per-pin de-bounce enable selects filter path
// - de-bounce advances only on slow clock
// - polarity bit picks active level
// - selector 0100 outputs loop lock directly
// - selector 0101 outputs temperature status directly
`timescale 1ns/1ps
`default_nettype none
module cig_logic
  import cig_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic [5:0] pin_in_i,
  output logic [5:0] pin_out_o,
  output logic [5:0] pin_oe_o,
  output logic [5:0] pin_pullup_enable_o,
  output logic [5:0] pin_pulldown_enable_o,
  input wire logic [1:0] jack_detect_i,
  input wire logic [2:0] microphone_bias_i,
  input wire logic loop_lock_i,
  input wire logic temp_ok_i,
  input wire logic slow_timeout_clock_i
);
  typedef struct packed {
    logic [15:0] stat;
    logic [15:0] en;
    logic [15:0] pol;
    logic [23:0] sel;
    logic [23:0] pad;
    logic tick_q;
    logic [7:0] deb;
    logic [7:0][2:0] cnt;
    logic flag;
    logic [5:0] pout;
    logic [5:0] poe;
    logic aw_got;
    logic w_got;
    logic [5:0] awidx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cig_st_t;

  cig_st_t st_ff;
  cig_st_t nxt_st;

  logic [7:0] raw_in;
  logic [7:0] filt;
  logic [7:0] blk;
  logic [7:0] deb_n;
  logic [7:0][2:0] cnt_n;
  logic [5:0] pin_val;
  logic [15:0] src_act;
  logic [15:0] clr;
  logic tick;
  logic any_en;
  logic flag_pin;

  function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign raw_in = {jack_detect_i, pin_in_i};
  assign tick = slow_timeout_clock_i & ~st_ff.tick_q;
  assign any_en = |(st_ff.stat & st_ff.en & SRC_MASK);
  assign flag_pin = any_en ^ st_ff.pol[BIT_FLAG];

  for (genvar k = 0; k < 8; k++) begin : g_in
    logic chg;
    logic [2:0] inc;
    assign chg = raw_in[k] != st_ff.deb[k];
    assign inc = 3'(st_ff.cnt[k] + 3'h1);
    assign deb_n[k] = (chg && tick && inc == DEB_TICKS) ? raw_in[k] : st_ff.deb[k];
    assign cnt_n[k] = !chg ? 3'h0 : (!tick ? st_ff.cnt[k] : (inc == DEB_TICKS ? 3'h0 : inc));
    assign filt[k] = st_ff.pad[PAD_DEB + k] ? st_ff.deb[k] : raw_in[k];
    assign src_act[k] = ~blk[k] & (filt[k] ^ st_ff.pol[k]);
    if (k < 6) begin : g_pin
      logic [3:0] s;
      assign s = st_ff.sel[4*k +: 4];
      assign blk[k] = s inside {SEL_LOW, SEL_HIGH, SEL_LOCK, SEL_TEMP, SEL_FLAG};
      assign pin_val[k] = (s == SEL_HIGH) | (s == SEL_LOCK & loop_lock_i)
                        | (s == SEL_TEMP & temp_ok_i) | (s == SEL_FLAG & flag_pin);
    end else begin : g_jack
      assign blk[k] = 1'b0;
    end
  end

  always_comb begin
    src_act[15:8] = 8'h00;
    src_act[BIT_LOCK] = loop_lock_i ^ st_ff.pol[BIT_LOCK];
    src_act[BIT_MB_CUR] = microphone_bias_i[0] ^ st_ff.pol[BIT_MB_CUR];
    src_act[BIT_MB_SHORT] = microphone_bias_i[1] ^ st_ff.pol[BIT_MB_SHORT];
    src_act[BIT_TEMP] = temp_ok_i ^ st_ff.pol[BIT_TEMP];
    src_act[BIT_MB_ACC] = microphone_bias_i[2] ^ st_ff.pol[BIT_MB_ACC];
  end

  always_comb begin
    logic awhs;
    logic whs;
    logic arhs;
    logic awn;
    logic wn;
    logic fire;
    logic [5:0] widx;
    logic [5:0] ridx;
    logic [31:0] wd;
    logic [3:0] ws;
    awhs = s_awvalid_i & st_ff.awrdy;
    whs = s_wvalid_i & st_ff.wrdy;
    arhs = s_arvalid_i & st_ff.arrdy;
    awn = st_ff.aw_got | awhs;
    wn = st_ff.w_got | whs;
    fire = awn & wn & ~st_ff.bvalid;
    widx = awhs ? s_awaddr_i[7:2] : st_ff.awidx;
    ridx = s_araddr_i[7:2];
    wd = whs ? s_wdata_i : st_ff.wdata;
    ws = whs ? s_wstrb_i : st_ff.wstrb;
    nxt_st = st_ff;
    clr = 16'h0000;
    nxt_st.aw_got = awn & ~fire;
    nxt_st.w_got = wn & ~fire;
    nxt_st.awidx = widx;
    nxt_st.wdata = wd;
    nxt_st.wstrb = ws;
    nxt_st.bvalid = fire | (st_ff.bvalid & ~s_bready_i);
    nxt_st.awrdy = ~nxt_st.aw_got & ~nxt_st.bvalid;
    nxt_st.wrdy = ~nxt_st.w_got & ~nxt_st.bvalid;
    if (fire) begin
      nxt_st.bresp = RESP_OKAY;
      unique case (widx)
        IDX_STAT: clr = 16'(wmerge(32'h00000000, wd, ws)) & SRC_MASK;
        IDX_EN: nxt_st.en = 16'(wmerge({16'h0000, st_ff.en}, wd, ws)) & SRC_MASK;
        IDX_POL: nxt_st.pol = 16'(wmerge({16'h0000, st_ff.pol}, wd, ws)) & POL_MASK;
        IDX_SEL: nxt_st.sel = 24'(wmerge({8'h00, st_ff.sel}, wd, ws));
        IDX_PAD: nxt_st.pad = 24'(wmerge({8'h00, st_ff.pad}, wd, ws)) & 24'hFF3F3F;
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end
    nxt_st.rvalid = arhs | (st_ff.rvalid & ~s_rready_i);
    nxt_st.arrdy = ~nxt_st.rvalid;
    if (arhs) begin
      nxt_st.rresp = RESP_OKAY;
      unique case (ridx)
        IDX_STAT: nxt_st.rdata = {16'h0000, st_ff.stat | (16'(st_ff.flag) << BIT_FLAG)};
        IDX_EN: nxt_st.rdata = {16'h0000, st_ff.en};
        IDX_POL: nxt_st.rdata = {16'h0000, st_ff.pol};
        IDX_SEL: nxt_st.rdata = {8'h00, st_ff.sel};
        IDX_PAD: nxt_st.rdata = {8'h00, st_ff.pad};
        default: begin
          nxt_st.rdata = 32'h00000000;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_st.stat = ((st_ff.stat & ~clr) | src_act) & SRC_MASK;
    nxt_st.flag = any_en;
    nxt_st.tick_q = slow_timeout_clock_i;
    nxt_st.deb = deb_n;
    nxt_st.cnt = cnt_n;
    nxt_st.pout = pin_val;
    nxt_st.poe = blk[5:0];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.pol <= POL_RST;
      st_ff.en <= EN_RST;
      st_ff.sel <= SEL_RST;
      st_ff.pad <= PAD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_awready_o = st_ff.awrdy;
  assign s_wready_o = st_ff.wrdy;
  assign s_bvalid_o = st_ff.bvalid;
  assign s_bresp_o = st_ff.bresp;
  assign s_arready_o = st_ff.arrdy;
  assign s_rvalid_o = st_ff.rvalid;
  assign s_rresp_o = st_ff.rresp;
  assign s_rdata_o = st_ff.rdata;
  assign pin_out_o = st_ff.pout;
  assign pin_oe_o = st_ff.poe;
  assign pin_pullup_enable_o = st_ff.pad[PAD_PU +: 6];
  assign pin_pulldown_enable_o = st_ff.pad[PAD_PD +: 6];

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_CONST_LOW: assert property ((st_ff.sel[3:0] == SEL_LOW) |=> (!pin_out_o[0] && pin_oe_o[0]))
    else $error("constant low not driven");
  AST_CONST_HIGH: assert property ((st_ff.sel[7:4] == SEL_HIGH) |=> (pin_out_o[1] && pin_oe_o[1]))
    else $error("constant high not driven");
  AST_FLAG_OR: assert property (##1 st_ff.flag == $past(any_en))
    else $error("flag differs from enabled status OR");
  AST_FLAG_PIN: assert property ((st_ff.sel[19:16] == SEL_FLAG) |=> pin_out_o[4] == $past(flag_pin))
    else $error("flag not routed to pin");
  AST_INVERT: assert property ((st_ff.pol[BIT_FLAG] && st_ff.sel[19:16] == SEL_FLAG)
    |=> pin_out_o[4] != $past(any_en))
    else $error("flag pin not inverted");
  AST_LATCH: assert property (##1 (st_ff.stat & $past(src_act) & SRC_MASK) == ($past(src_act) & SRC_MASK))
    else $error("active source did not set status");
  AST_HOLD: assert property (##1 ((st_ff.stat | $past(clr)) & $past(st_ff.stat)) == $past(st_ff.stat))
    else $error("status dropped without a clear");
  AST_ENABLE: assert property ((st_ff.en == 16'h0000) |=> !st_ff.flag)
    else $error("flag set with no enables");
  AST_BLOCK: assert property ((st_ff.sel[3:0] == SEL_LOW) |-> !src_act[0])
    else $error("output pin fed its own input");
  AST_LOCK_OUT: assert property ((st_ff.sel[11:8] == SEL_LOCK) |=> pin_out_o[2] == $past(loop_lock_i))
    else $error("lock not on pin");
  AST_TEMP_OUT: assert property ((st_ff.sel[15:12] == SEL_TEMP) |=> pin_out_o[3] == $past(temp_ok_i))
    else $error("temperature not on pin");
  AST_BYPASS: assert property (!st_ff.pad[PAD_DEB] |-> filt[0] == pin_in_i[0])
    else $error("bypass path not raw");
  AST_DEB_STILL: assert property (!tick |=> st_ff.deb == $past(st_ff.deb))
    else $error("filter moved without slow clock");
  AST_READBACK: assert property ((s_arvalid_i && s_arready_o && s_araddr_i[7:2] == IDX_STAT)
    |=> s_rdata_o[BIT_FLAG] == $past(st_ff.flag))
    else $error("flag readback wrong");
  AST_FLAG_HOLD: assert property ((st_ff.flag && any_en) |=> st_ff.flag)
    else $error("flag dropped while enabled status set");
  AST_DISABLED_SET: assert property ((src_act[BIT_LOCK] && !st_ff.en[BIT_LOCK]) |=> st_ff.stat[BIT_LOCK])
    else $error("disabled source did not latch");
  AST_POL_LOW: assert property ((!st_ff.pad[PAD_DEB] && !blk[0] && (pin_in_i[0] ^ st_ff.pol[0])) |=> st_ff.stat[0])
    else $error("active level did not set pin status");
  AST_JACK: assert property ((jack_detect_i[0] != st_ff.pol[6] && !st_ff.pad[PAD_DEB + 6]) |=> st_ff.stat[6])
    else $error("jack source did not latch");
  AST_TEMP_SRC: assert property ((temp_ok_i ^ st_ff.pol[BIT_TEMP]) |=> st_ff.stat[BIT_TEMP])
    else $error("temperature source did not latch");
  AST_CLEAR: assert property ((clr[BIT_LOCK] && !src_act[BIT_LOCK]) |=> !st_ff.stat[BIT_LOCK])
    else $error("write one did not clear status");
  AST_DEB_PASS: assert property ((tick && raw_in[1] != st_ff.deb[1] && st_ff.cnt[1] == DEB_TICKS - 3'h1)
    |=> st_ff.deb[1] == $past(raw_in[1]))
    else $error("filter did not pass stable change");
  AST_DEB_WAIT: assert property ((raw_in[1] != st_ff.deb[1] && st_ff.cnt[1] != DEB_TICKS - 3'h1)
    |=> st_ff.deb[1] == $past(st_ff.deb[1]))
    else $error("filter passed change too early");
  AST_DEB_PATH: assert property (st_ff.pad[PAD_DEB + 1] |-> filt[1] == st_ff.deb[1])
    else $error("filtered path not selected");
  AST_OE_IN: assert property ((st_ff.sel[23:20] == 4'h0) |=> !pin_oe_o[5])
    else $error("input pin driven");
endmodule
`default_nettype wire

// *** src/cig_pkg.sv ***
// cig_pkg: constants for the codec interrupt and general-purpose pin block.
// assumes one 20 MHz clock and AXI4-Lite register access.
package cig_pkg;
  localparam int CLK_MHZ = 20;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_STAT = 6'h12;
  localparam logic [5:0] IDX_EN = 6'h16;
  localparam logic [5:0] IDX_POL = 6'h17;
  localparam logic [5:0] IDX_SEL = 6'h20;
  localparam logic [5:0] IDX_PAD = 6'h21;
  // status/enable/polarity bit positions
  localparam int BIT_LOCK = 8;
  localparam int BIT_MB_CUR = 9;
  localparam int BIT_MB_SHORT = 10;
  localparam int BIT_TEMP = 11;
  localparam int BIT_FLAG = 12;
  localparam int BIT_MB_ACC = 13;
  localparam logic [15:0] SRC_MASK = 16'h2FFF;
  localparam logic [15:0] POL_MASK = 16'h3FFF;
  localparam logic [15:0] POL_RST = 16'h0800;
  localparam logic [15:0] EN_RST = 16'h0000;
  localparam logic [23:0] SEL_RST = 24'h000000;
  localparam logic [23:0] PAD_RST = 24'h000000;
  // pad register fields
  localparam int PAD_PU = 0;
  localparam int PAD_PD = 8;
  localparam int PAD_DEB = 16;
  // pin function selector codes
  localparam logic [3:0] SEL_LOW = 4'h2;
  localparam logic [3:0] SEL_HIGH = 4'h3;
  localparam logic [3:0] SEL_LOCK = 4'h4;
  localparam logic [3:0] SEL_TEMP = 4'h5;
  localparam logic [3:0] SEL_FLAG = 4'h7;
  // stable slow-clock periods before a de-bounced change passes
  localparam logic [2:0] DEB_TICKS = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** bench/cig_host.sv ***
// cig_host: host interrupt input watching one pin of the block.
// assumes the pin floats while its enable is low.
`timescale 1ns/1ps
`default_nettype none
module cig_host (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic oe_i,
  input wire logic active_low_i,
  output logic irq_o
);
  logic irq_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= oe_i & (pin_i ^ active_low_i);
    end
  end
  assign irq_o = irq_ff;
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// tb: self-checking bench for cig_logic over AXI4-Lite.
// assumes the host model watches pin 4 as its interrupt input.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cig_pkg::*;
  localparam logic [7:0] A_ST = {IDX_STAT, 2'b00};
  localparam logic [7:0] A_EN = {IDX_EN, 2'b00};
  localparam logic [7:0] A_POL = {IDX_POL, 2'b00};
  localparam logic [7:0] A_SEL = {IDX_SEL, 2'b00};
  localparam logic [7:0] A_PAD = {IDX_PAD, 2'b00};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] s_awaddr_i = 8'h00;
  logic [7:0] s_araddr_i = 8'h00;
  logic [31:0] s_wdata_i = 32'h0;
  logic [3:0] s_wstrb_i = 4'hF;
  logic s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
  logic s_arvalid_i = 1'b0, s_rready_i = 1'b0;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [1:0] s_bresp_o, s_rresp_o, wresp, rsp;
  logic [31:0] s_rdata_o, rdv;
  logic [5:0] pin_in_i = 6'h00;
  logic [5:0] pin_out_o, pin_oe_o, pin_pullup_enable_o, pin_pulldown_enable_o;
  logic [1:0] jack_detect_i = 2'h0;
  logic [2:0] microphone_bias_i = 3'h0;
  logic loop_lock_i = 1'b0, temp_ok_i = 1'b1, slow_timeout_clock_i = 1'b0;
  logic host_inv = 1'b0, host_irq;
  int n_fail = 0;
  int checks = 0;
  always #25 clk_i = ~clk_i;
  cig_logic DUT (.clk_i, .rst_n_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o,
    .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o,
    .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o,
    .s_rresp_o, .s_rvalid_o, .s_rready_i, .pin_in_i, .pin_out_o, .pin_oe_o,
    .pin_pullup_enable_o, .pin_pulldown_enable_o, .jack_detect_i,
    .microphone_bias_i, .loop_lock_i, .temp_ok_i, .slow_timeout_clock_i);
  cig_host host (.clk_i, .rst_n_i, .pin_i(pin_out_o[4]), .oe_i(pin_oe_o[4]),
    .active_low_i(host_inv), .irq_o(host_irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_awready_o === 1'b1) s_awvalid_i <= 1'b0;
      if (s_wready_o === 1'b1) s_wvalid_i <= 1'b0;
    end while (s_bvalid_o !== 1'b1);
    wresp = s_bresp_o;
    s_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_arready_o === 1'b1) s_arvalid_i <= 1'b0;
    end while (s_rvalid_o !== 1'b1);
    rdv = s_rdata_o;
    rsp = s_rresp_o;
    s_rready_i <= 1'b0;
  endtask
  task automatic tick;
    slow_timeout_clock_i <= 1'b1;
    cyc(2);
    slow_timeout_clock_i <= 1'b0;
    cyc(2);
  endtask
  task automatic t_reset;
    rd(A_POL);
    chk(rdv, {16'h0, POL_RST});
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(A_ST);
    chk(rdv, 32'h0);
    rd(8'h00);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h04, 32'hFFFF);
    chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
  endtask
  task automatic t_latch;
    loop_lock_i <= 1'b1;
    cyc(3);
    rd(A_ST);
    chk(rdv, 32'h0100);
    wr(A_EN, 32'h0100);
    rd(A_ST);
    chk(rdv, 32'h1100);
    wr(A_ST, 32'h1000);
    rd(A_ST);
    chk(rdv, 32'h1100);
    wr(A_ST, 32'h0100);
    rd(A_ST);
    chk(rdv, 32'h1100);
    loop_lock_i <= 1'b0;
    wr(A_ST, 32'h0100);
    rd(A_ST);
    chk(rdv, 32'h0);
    $display("test latch done");
  endtask
  task automatic t_src;
    jack_detect_i <= 2'h3;
    microphone_bias_i <= 3'h7;
    cyc(3);
    rd(A_ST);
    chk(rdv, 32'h26C0);
    jack_detect_i <= 2'h0;
    microphone_bias_i <= 3'h0;
    wr(A_ST, 32'h26C0);
    rd(A_ST);
    chk(rdv, 32'h0);
    $display("test sources done");
  endtask
  task automatic t_pol;
    // active low: high level must not latch
    wr(A_POL, 32'h0801);
    pin_in_i <= 6'h01;
    cyc(2);
    wr(A_ST, 32'h1);
    rd(A_ST);
    chk(rdv, 32'h0);
    pin_in_i <= 6'h00;
    cyc(3);
    rd(A_ST);
    chk(rdv, 32'h1);
    wr(A_POL, 32'h0800);
    wr(A_ST, 32'h1);
    rd(A_ST);
    chk(rdv, 32'h0);
    pin_in_i <= 6'h01;
    cyc(3);
    rd(A_ST);
    chk(rdv, 32'h1);
    pin_in_i <= 6'h00;
    wr(A_ST, 32'h1);
    $display("test polarity done");
  endtask
  task automatic t_deb;
    wr(A_PAD, 32'h0002_0000);
    pin_in_i <= 6'h02;
    cyc(20);
    rd(A_ST);
    chk(rdv, 32'h0);
    repeat (3) tick;
    rd(A_ST);
    chk(rdv, 32'h0);
    tick;
    cyc(3);
    rd(A_ST);
    chk(rdv, 32'h2);
    $display("test debounce done");
  endtask
  task automatic t_out;
    wr(A_PAD, 32'h0);
    loop_lock_i <= 1'b1;
    temp_ok_i <= 1'b0;
    wr(A_SEL, 32'h0007_5432);
    cyc(3);
    chk({26'h0, pin_out_o}, 32'h16);
    chk({26'h0, pin_oe_o}, 32'h1F);
    chk({26'h0, pin_pullup_enable_o | pin_pulldown_enable_o}, 32'h0);
    chk({31'h0, host_irq}, 32'h1);
    host_inv <= 1'b1;
    wr(A_POL, 32'h1800);
    cyc(3);
    chk({26'h0, pin_out_o}, 32'h06);
    chk({31'h0, host_irq}, 32'h1);
    pin_in_i <= 6'h01;
    cyc(3);
    rd(A_ST);
    chk(rdv & 32'h1, 32'h0);
    $display("test outputs done");
  endtask
  task automatic end_sim;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(3);
    t_reset;
    t_latch;
    t_src;
    t_pol;
    t_deb;
    t_out;
    end_sim;
  end
endmodule
`default_nettype wire
